/* File: verilog/codec_clock_path_pkg.sv */
// Register map, field layout and reset values of the clock path registers
package codec_clock_path_pkg;

    localparam logic [7:0] OFS_PLL_ENABLE_DIVIDERS    = 8'h03;
    localparam logic [7:0] OFS_PLL_INTEGER_MULTIPLIER = 8'h04;
    localparam logic [7:0] OFS_PLL_FRACTION_HIGH      = 8'h05;
    localparam logic [7:0] OFS_PLL_FRACTION_LOW       = 8'h06;
    localparam logic [7:0] OFS_DATAPATH_SETUP         = 8'h07;
    localparam logic [7:0] OFS_SERIAL_PORT_CONTROL_A  = 8'h08;

    localparam logic [7:0] RST_PLL_ENABLE_DIVIDERS    = 8'h10;
    localparam logic [7:0] RST_PLL_INTEGER_MULTIPLIER = 8'h04;
    localparam logic [7:0] RST_PLL_FRACTION_HIGH      = 8'h00;
    localparam logic [7:0] RST_PLL_FRACTION_LOW       = 8'h00;
    localparam logic [7:0] RST_DATAPATH_SETUP         = 8'h00;
    localparam logic [7:0] RST_SERIAL_PORT_CONTROL_A  = 8'h00;

    // Writable bits; reserved bits stay zero
    localparam logic [7:0] WMASK_PLL_ENABLE_DIVIDERS    = 8'hff;
    localparam logic [7:0] WMASK_PLL_INTEGER_MULTIPLIER = 8'hfc;
    localparam logic [7:0] WMASK_PLL_FRACTION_HIGH      = 8'hff;
    localparam logic [7:0] WMASK_PLL_FRACTION_LOW       = 8'hfc;
    localparam logic [7:0] WMASK_DATAPATH_SETUP         = 8'hfe;
    localparam logic [7:0] WMASK_SERIAL_PORT_CONTROL_A  = 8'hf7;

    localparam int PLL_EN_BIT    = 7;
    localparam int PLL_Q_MSB     = 6;
    localparam int PLL_Q_LSB     = 3;
    localparam int PLL_P_MSB     = 2;
    localparam int PLL_P_LSB     = 0;
    localparam int PLL_J_MSB     = 7;
    localparam int PLL_J_LSB     = 2;
    localparam int FRAC_LO_MSB   = 7;
    localparam int FRAC_LO_LSB   = 2;
    localparam int FSREF_BIT     = 7;
    localparam int ADC_DUAL_BIT  = 6;
    localparam int DAC_DUAL_BIT  = 5;
    localparam int LROUTE_MSB    = 4;
    localparam int LROUTE_LSB    = 3;
    localparam int RROUTE_MSB    = 2;
    localparam int RROUTE_LSB    = 1;
    localparam int BCLK_DIR_BIT  = 7;
    localparam int WCLK_DIR_BIT  = 6;
    localparam int DOUT_TRI_BIT  = 5;
    localparam int CLK_KEEP_BIT  = 4;
    localparam int FX3D_BIT      = 2;
    localparam int DMIC_MSB      = 1;
    localparam int DMIC_LSB      = 0;

    localparam logic [4:0] PLL_Q_WRAP   = 5'h10;
    localparam logic [3:0] PLL_P_ZERO   = 4'h8;
    localparam logic [7:0] DMIC_OSR_01  = 8'h80;
    localparam logic [7:0] DMIC_OSR_10  = 8'h40;
    localparam logic [7:0] DMIC_OSR_11  = 8'h20;

    localparam logic [6:0] DEFAULT_BUS_ADDRESS = 7'h18;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_PTR,
        ST_ACK_PTR,
        ST_WDATA,
        ST_ACK_WDATA,
        ST_RDATA,
        ST_RACK
    } bus_state_t;

endpackage : codec_clock_path_pkg

/* File: verilog/pin_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.first  = async_i;
        s_nxt.second = s_r.first;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign sync_o = s_r.second;

endmodule : pin_sync

`default_nettype wire

/* File: verilog/codec_clock_path_config_regs.sv */
// Clock path, data path and serial port configuration registers
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Fractional PLL runs only while enable bit set
// - Divider codes 0,1 mean 16,17; reset 2
// - Pre-divider code 0 means 8
// - Multiplier 1..63, reset 1; zero reserved
// - Fraction upper eight bits from high register
// - Fraction lower six bits; bits 1:0 zero
// - Bit 7 picks 48 or 44.1 kHz
// - Separate dual-rate enables; host keeps equal
// - Left DAC route: mute, left, right, mono
// - Right DAC route: mute, right, left, mono
// - Bit clock driven when master bit set, while powered up or with the keep bit set
// - Frame clock driven when master bit set, while powered up or with the keep bit set
// - Data output floats between valid data
// - Master clocks keep running at power-down
// - 3-D effect only while bit set
// - Microphone field: off, 128, 64, 32
// - Eight-bit registers reached at own address
module codec_clock_path_config_regs #(
    parameter logic [6:0] BUS_ADDRESS =
        codec_clock_path_pkg::DEFAULT_BUS_ADDRESS
) (
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic        codec_powered_down_i,
    input  wire logic        bclk_gen_i,
    input  wire logic        wclk_gen_i,
    input  wire logic        bclk_i,
    input  wire logic        wclk_i,
    output logic             bclk_o,
    output logic             bclk_oe_o,
    output logic             wclk_o,
    output logic             wclk_oe_o,
    output logic             bclk_rise_o,
    output logic             wclk_rise_o,
    input  wire logic        dout_valid_i,
    input  wire logic        dout_bit_i,
    output logic             dout_o,
    output logic             dout_oe_o,
    output logic             pll_enable_o,
    output logic [4:0]       pll_q_divider_o,
    output logic [3:0]       pll_p_divider_o,
    output logic [5:0]       pll_j_multiplier_o,
    output logic [13:0]      pll_fraction_o,
    output logic             fs_ref_44k1_o,
    output logic             adc_dual_rate_o,
    output logic             dac_dual_rate_o,
    output logic [1:0]       left_dac_route_o,
    output logic [1:0]       right_dac_route_o,
    output logic             effect_3d_o,
    output logic             dmic_enable_o,
    output logic [7:0]       dmic_osr_o
);

    typedef struct packed {
        codec_clock_path_pkg::bus_state_t state;
        logic [7:0]  shift;
        logic [3:0]  bitcnt;
        logic        rw;
        logic        nack;
        logic [7:0]  ptr;
        logic        sda_oe;
        logic        scl_d;
        logic        sda_d;
        logic        bclk_d;
        logic        wclk_d;
        logic [7:0]  reg_pll_a;
        logic [7:0]  reg_pll_b;
        logic [7:0]  reg_frac_hi;
        logic [7:0]  reg_frac_lo;
        logic [7:0]  reg_datapath;
        logic [7:0]  reg_port_a;
        logic [13:0] fraction;
        logic        bclk_out;
        logic        bclk_oe;
        logic        wclk_out;
        logic        wclk_oe;
        logic        bclk_rise;
        logic        wclk_rise;
        logic        dout;
        logic        dout_oe;
    } regs_state_t;

    regs_state_t s_r;
    regs_state_t s_nxt;
    logic [3:0]  pins_sync;
    logic        scl_s;
    logic        sda_s;
    logic        bclk_s;
    logic        wclk_s;

    pin_sync #(
        .WIDTH (4)
    ) u_pin_sync (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .async_i  ({scl_i, sda_i, bclk_i, wclk_i}),
        .sync_o   (pins_sync)
    );

    assign {scl_s, sda_s, bclk_s, wclk_s} = pins_sync;

    // Readback of a register; unmapped offsets read zero
    function automatic logic [7:0] read_reg(input regs_state_t s,
                                            input logic [7:0]  ofs);
        case (ofs)
            codec_clock_path_pkg::OFS_PLL_ENABLE_DIVIDERS:
                read_reg = s.reg_pll_a;
            codec_clock_path_pkg::OFS_PLL_INTEGER_MULTIPLIER:
                read_reg = s.reg_pll_b;
            codec_clock_path_pkg::OFS_PLL_FRACTION_HIGH:
                read_reg = s.reg_frac_hi;
            codec_clock_path_pkg::OFS_PLL_FRACTION_LOW:
                read_reg = s.reg_frac_lo;
            codec_clock_path_pkg::OFS_DATAPATH_SETUP:
                read_reg = s.reg_datapath;
            codec_clock_path_pkg::OFS_SERIAL_PORT_CONTROL_A:
                read_reg = s.reg_port_a;
            default:
                read_reg = 8'h00;
        endcase
    endfunction : read_reg

    always_comb
    begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic [7:0] rd;
        logic master_run;
        scl_rise   = 1'b0;
        scl_fall   = 1'b0;
        start_c    = 1'b0;
        stop_c     = 1'b0;
        rd         = 8'h00;
        master_run = 1'b0;
        s_nxt      = s_r;

        s_nxt.scl_d  = scl_s;
        s_nxt.sda_d  = sda_s;
        s_nxt.bclk_d = bclk_s;
        s_nxt.wclk_d = wclk_s;
        scl_rise = scl_s & ~s_r.scl_d;
        scl_fall = ~scl_s & s_r.scl_d;
        start_c  = scl_s & s_r.scl_d & s_r.sda_d & ~sda_s;
        stop_c   = scl_s & s_r.scl_d & ~s_r.sda_d & sda_s;

        if (start_c)
        begin
            s_nxt.state  = codec_clock_path_pkg::ST_ADDR;
            s_nxt.bitcnt = 4'h0;
            s_nxt.sda_oe = 1'b0;
        end
        else if (stop_c)
        begin
            s_nxt.state  = codec_clock_path_pkg::ST_IDLE;
            s_nxt.sda_oe = 1'b0;
        end
        else
        begin
            case (s_r.state)
                codec_clock_path_pkg::ST_ADDR,
                codec_clock_path_pkg::ST_PTR,
                codec_clock_path_pkg::ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        s_nxt.shift  = {s_r.shift[6:0], sda_s};
                        s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                    end
                    else if (scl_fall && s_r.bitcnt == 4'h8)
                    begin
                        s_nxt.sda_oe = 1'b1;
                        if (s_r.state == codec_clock_path_pkg::ST_ADDR)
                        begin
                            // Answer only at this partition's address
                            if (s_r.shift[7:1] == BUS_ADDRESS)
                            begin
                                s_nxt.rw    = s_r.shift[0];
                                s_nxt.state =
                                    codec_clock_path_pkg::ST_ACK_ADDR;
                            end
                            else
                            begin
                                s_nxt.sda_oe = 1'b0;
                                s_nxt.state  = codec_clock_path_pkg::ST_IDLE;
                            end
                        end
                        else if (s_r.state == codec_clock_path_pkg::ST_PTR)
                        begin
                            s_nxt.ptr   = s_r.shift;
                            s_nxt.state = codec_clock_path_pkg::ST_ACK_PTR;
                        end
                        else
                        begin
                            s_nxt.ptr   = s_r.ptr + 8'h01;
                            s_nxt.state = codec_clock_path_pkg::ST_ACK_WDATA;
                            case (s_r.ptr)
                                codec_clock_path_pkg::OFS_PLL_ENABLE_DIVIDERS:
                                    s_nxt.reg_pll_a = s_r.shift &
                                        codec_clock_path_pkg::WMASK_PLL_ENABLE_DIVIDERS;
                                codec_clock_path_pkg::OFS_PLL_INTEGER_MULTIPLIER:
                                    s_nxt.reg_pll_b = s_r.shift &
                                        codec_clock_path_pkg::WMASK_PLL_INTEGER_MULTIPLIER;
                                codec_clock_path_pkg::OFS_PLL_FRACTION_HIGH:
                                    s_nxt.reg_frac_hi = s_r.shift &
                                        codec_clock_path_pkg::WMASK_PLL_FRACTION_HIGH;
                                codec_clock_path_pkg::OFS_PLL_FRACTION_LOW:
                                begin
                                    s_nxt.reg_frac_lo = s_r.shift &
                                        codec_clock_path_pkg::WMASK_PLL_FRACTION_LOW;
                                    // Low-half write commits both halves
                                    s_nxt.fraction = {s_r.reg_frac_hi,
                                        s_r.shift[codec_clock_path_pkg::FRAC_LO_MSB:
                                                  codec_clock_path_pkg::FRAC_LO_LSB]};
                                end
                                codec_clock_path_pkg::OFS_DATAPATH_SETUP:
                                    s_nxt.reg_datapath = s_r.shift &
                                        codec_clock_path_pkg::WMASK_DATAPATH_SETUP;
                                codec_clock_path_pkg::OFS_SERIAL_PORT_CONTROL_A:
                                    s_nxt.reg_port_a = s_r.shift &
                                        codec_clock_path_pkg::WMASK_SERIAL_PORT_CONTROL_A;
                                default:
                                    s_nxt.reg_pll_a = s_r.reg_pll_a;
                            endcase
                        end
                    end
                end
                codec_clock_path_pkg::ST_ACK_ADDR,
                codec_clock_path_pkg::ST_ACK_PTR,
                codec_clock_path_pkg::ST_ACK_WDATA:
                begin
                    if (scl_fall)
                    begin
                        s_nxt.bitcnt = 4'h0;
                        s_nxt.sda_oe = 1'b0;
                        if (s_r.state == codec_clock_path_pkg::ST_ACK_ADDR
                            && s_r.rw)
                        begin
                            rd           = read_reg(s_r, s_r.ptr);
                            s_nxt.shift  = rd;
                            s_nxt.sda_oe = ~rd[7];
                            s_nxt.ptr    = s_r.ptr + 8'h01;
                            s_nxt.state  = codec_clock_path_pkg::ST_RDATA;
                        end
                        else if (s_r.state == codec_clock_path_pkg::ST_ACK_ADDR)
                            s_nxt.state = codec_clock_path_pkg::ST_PTR;
                        else
                            s_nxt.state = codec_clock_path_pkg::ST_WDATA;
                    end
                end
                codec_clock_path_pkg::ST_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (s_r.bitcnt == 4'h7)
                        begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.state  = codec_clock_path_pkg::ST_RACK;
                        end
                        else
                        begin
                            s_nxt.shift  = {s_r.shift[6:0], 1'b0};
                            s_nxt.sda_oe = ~s_r.shift[6];
                            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                        end
                    end
                end
                codec_clock_path_pkg::ST_RACK:
                begin
                    if (scl_rise)
                        s_nxt.nack = sda_s;
                    else if (scl_fall)
                    begin
                        if (s_r.nack)
                            s_nxt.state = codec_clock_path_pkg::ST_IDLE;
                        else
                        begin
                            rd           = read_reg(s_r, s_r.ptr);
                            s_nxt.shift  = rd;
                            s_nxt.sda_oe = ~rd[7];
                            s_nxt.bitcnt = 4'h0;
                            s_nxt.ptr    = s_r.ptr + 8'h01;
                            s_nxt.state  = codec_clock_path_pkg::ST_RDATA;
                        end
                    end
                end
                default:
                    s_nxt.sda_oe = 1'b0;
            endcase
        end

        // Serial port pins
        master_run = ~codec_powered_down_i |
                     s_r.reg_port_a[codec_clock_path_pkg::CLK_KEEP_BIT];
        s_nxt.bclk_out = bclk_gen_i;
        s_nxt.wclk_out = wclk_gen_i;
        s_nxt.bclk_oe  = s_r.reg_port_a[codec_clock_path_pkg::BCLK_DIR_BIT]
                         & master_run;
        s_nxt.wclk_oe  = s_r.reg_port_a[codec_clock_path_pkg::WCLK_DIR_BIT]
                         & master_run;
        // Slave mode follows the pin, master mode the own generator
        s_nxt.bclk_rise = s_r.reg_port_a[codec_clock_path_pkg::BCLK_DIR_BIT] ?
                          (bclk_gen_i & ~s_r.bclk_out) :
                          (bclk_s & ~s_r.bclk_d);
        s_nxt.wclk_rise = s_r.reg_port_a[codec_clock_path_pkg::WCLK_DIR_BIT] ?
                          (wclk_gen_i & ~s_r.wclk_out) :
                          (wclk_s & ~s_r.wclk_d);
        s_nxt.dout    = dout_valid_i & dout_bit_i;
        s_nxt.dout_oe = dout_valid_i |
                        ~s_r.reg_port_a[codec_clock_path_pkg::DOUT_TRI_BIT];
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_r              <= '0;
            s_r.state        <= codec_clock_path_pkg::ST_IDLE;
            s_r.scl_d        <= 1'b1;
            s_r.sda_d        <= 1'b1;
            s_r.reg_pll_a    <= codec_clock_path_pkg::RST_PLL_ENABLE_DIVIDERS;
            s_r.reg_pll_b    <= codec_clock_path_pkg::RST_PLL_INTEGER_MULTIPLIER;
            s_r.reg_frac_hi  <= codec_clock_path_pkg::RST_PLL_FRACTION_HIGH;
            s_r.reg_frac_lo  <= codec_clock_path_pkg::RST_PLL_FRACTION_LOW;
            s_r.reg_datapath <= codec_clock_path_pkg::RST_DATAPATH_SETUP;
            s_r.reg_port_a   <= codec_clock_path_pkg::RST_SERIAL_PORT_CONTROL_A;
            s_r.dout_oe      <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign sda_o     = 1'b0;
    assign sda_oe_o  = s_r.sda_oe;
    assign bclk_o    = s_r.bclk_out;
    assign bclk_oe_o = s_r.bclk_oe;
    assign wclk_o    = s_r.wclk_out;
    assign wclk_oe_o = s_r.wclk_oe;
    assign bclk_rise_o = s_r.bclk_rise;
    assign wclk_rise_o = s_r.wclk_rise;
    assign dout_o    = s_r.dout;
    assign dout_oe_o = s_r.dout_oe;

    assign pll_enable_o = s_r.reg_pll_a[codec_clock_path_pkg::PLL_EN_BIT];
    always_comb
    begin
        logic [3:0] qc;
        logic [2:0] pc;
        qc = s_r.reg_pll_a[codec_clock_path_pkg::PLL_Q_MSB:
                           codec_clock_path_pkg::PLL_Q_LSB];
        pc = s_r.reg_pll_a[codec_clock_path_pkg::PLL_P_MSB:
                           codec_clock_path_pkg::PLL_P_LSB];
        pll_q_divider_o = (qc < 4'h2) ?
            (codec_clock_path_pkg::PLL_Q_WRAP | {4'h0, qc[0]}) :
            {1'b0, qc};
        pll_p_divider_o = (pc == 3'h0) ? codec_clock_path_pkg::PLL_P_ZERO :
                          {1'b0, pc};
        case (s_r.reg_port_a[codec_clock_path_pkg::DMIC_MSB:
                             codec_clock_path_pkg::DMIC_LSB])
            2'h1:    dmic_osr_o = codec_clock_path_pkg::DMIC_OSR_01;
            2'h2:    dmic_osr_o = codec_clock_path_pkg::DMIC_OSR_10;
            2'h3:    dmic_osr_o = codec_clock_path_pkg::DMIC_OSR_11;
            default: dmic_osr_o = 8'h00;
        endcase
    end
    assign pll_j_multiplier_o = s_r.reg_pll_b[codec_clock_path_pkg::PLL_J_MSB:
                                              codec_clock_path_pkg::PLL_J_LSB];
    assign pll_fraction_o  = s_r.fraction;
    assign fs_ref_44k1_o   = s_r.reg_datapath[codec_clock_path_pkg::FSREF_BIT];
    assign adc_dual_rate_o = s_r.reg_datapath[codec_clock_path_pkg::ADC_DUAL_BIT];
    assign dac_dual_rate_o = s_r.reg_datapath[codec_clock_path_pkg::DAC_DUAL_BIT];
    assign left_dac_route_o  = s_r.reg_datapath[codec_clock_path_pkg::LROUTE_MSB:
                                                codec_clock_path_pkg::LROUTE_LSB];
    assign right_dac_route_o = s_r.reg_datapath[codec_clock_path_pkg::RROUTE_MSB:
                                                codec_clock_path_pkg::RROUTE_LSB];
    assign effect_3d_o   = s_r.reg_port_a[codec_clock_path_pkg::FX3D_BIT];
    assign dmic_enable_o = |s_r.reg_port_a[codec_clock_path_pkg::DMIC_MSB:
                                           codec_clock_path_pkg::DMIC_LSB];

endmodule : codec_clock_path_config_regs

`default_nettype wire

/* File: verif/codec_clock_path_config_regs_props.sv */
// Port assertions for the clock path configuration registers
`timescale 1ns/1ps
`default_nettype none
module codec_regs_props (
    input wire logic       clock_i,
    input wire logic       resetn_i,
    input wire logic       bclk_gen_i,
    input wire logic       dout_valid_i,
    input wire logic       bclk_o,
    input wire logic       bclk_oe_o,
    input wire logic       bclk_rise_o,
    input wire logic       dout_oe_o,
    input wire logic       pll_enable_o,
    input wire logic [4:0] pll_q_divider_o,
    input wire logic [3:0] pll_p_divider_o,
    input wire logic [5:0] pll_j_multiplier_o,
    input wire logic       dmic_enable_o,
    input wire logic [7:0] dmic_osr_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    reset_vals_a: assert property ($rose(resetn_i) |->
        !pll_enable_o && pll_q_divider_o == 5'h02 && pll_p_divider_o == 4'h8
        && pll_j_multiplier_o == 6'h01) else $error("bad reset values");
    q_range_a: assert property (pll_q_divider_o inside {[5'h02:5'h11]})
        else $error("divider out of range");
    p_range_a: assert property (pll_p_divider_o inside {[4'h1:4'h8]})
        else $error("pre-divider out of range");
    j_nonzero_a: assert property (pll_j_multiplier_o != 6'h00)
        else $error("multiplier is zero");
    mic_ratio_a: assert property (dmic_enable_o == (dmic_osr_o != 8'h00) &&
        dmic_osr_o inside {8'h00, 8'h80, 8'h40, 8'h20}) else $error("mic ratio");
    bclk_master_a: assert property (bclk_oe_o |-> bclk_o == $past(bclk_gen_i))
        else $error("master bit clock");
    dout_float_a: assert property (!dout_oe_o |-> !$past(dout_valid_i))
        else $error("data floated while valid");
    rise_pulse_a: assert property (bclk_rise_o |=> !bclk_rise_o)
        else $error("rise pulse too long");
    cover property (bclk_oe_o);
    cover property (!dout_oe_o);
    cover property (dmic_enable_o && dmic_osr_o == 8'h20);
endmodule : codec_regs_props
bind codec_clock_path_config_regs codec_regs_props props_inst (.*);
`default_nettype wire

/* File: verif/audio_host_model.sv */
// Far-end audio processor clocking the serial port in slave mode
`timescale 1ns/1ps
`default_nettype none
module audio_host_model (
    input  wire logic bclk_o,
    input  wire logic bclk_oe_o,
    input  wire logic wclk_o,
    input  wire logic wclk_oe_o,
    output logic      bclk_i,
    output logic      wclk_i
);
    logic       host_bclk = 1'b0;
    logic [3:0] bit_cnt = 4'h0;
    // Link clock, unrelated in phase to the core clock
    initial
    begin
        #137;
        forever #200 host_bclk = ~host_bclk;
    end
    always @(negedge host_bclk)
        bit_cnt <= bit_cnt + 4'h1;
    assign bclk_i = bclk_oe_o ? bclk_o : host_bclk;
    assign wclk_i = wclk_oe_o ? wclk_o : bit_cnt[3];
endmodule : audio_host_model
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the clock path configuration registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [6:0] ADR = codec_clock_path_pkg::DEFAULT_BUS_ADDRESS;
    logic clock_i = 1'b0, resetn_i = 1'b0, scl_i = 1'b1, sda_h = 1'b1;
    logic codec_powered_down_i = 1'b0, ack, sda_i;
    logic [7:0] gen = 8'h00, v;
    logic [3:0] qv [4] = '{4'h0, 4'h1, 4'h2, 4'hf};
    int mismatches = 0, n_tests = 0, cycles = 0;
    logic sda_oe_o, bclk_o, bclk_oe_o, wclk_o, wclk_oe_o, bclk_rise_o, bclk_i;
    logic wclk_i, dout_oe_o, pll_enable_o, fs_ref_44k1_o, adc_dual_rate_o;
    logic dac_dual_rate_o, effect_3d_o, dmic_enable_o;
    logic [4:0] pll_q_divider_o;
    logic [3:0] pll_p_divider_o;
    logic [5:0] pll_j_multiplier_o;
    logic [13:0] pll_fraction_o;
    logic [1:0] left_dac_route_o, right_dac_route_o;
    logic [7:0] dmic_osr_o;
    assign sda_i = sda_h & !sda_oe_o;
    codec_clock_path_config_regs codec_clock_path_config_regs_inst (
        .clock_i, .resetn_i, .scl_i, .sda_i, .sda_o(), .sda_oe_o,
        .codec_powered_down_i, .bclk_gen_i(gen[2]), .wclk_gen_i(gen[5]),
        .bclk_i, .wclk_i, .bclk_o, .bclk_oe_o, .wclk_o, .wclk_oe_o,
        .bclk_rise_o, .wclk_rise_o(), .dout_valid_i(gen[6]),
        .dout_bit_i(gen[3]), .dout_o(), .dout_oe_o, .pll_enable_o,
        .pll_q_divider_o, .pll_p_divider_o, .pll_j_multiplier_o,
        .pll_fraction_o, .fs_ref_44k1_o, .adc_dual_rate_o, .dac_dual_rate_o,
        .left_dac_route_o, .right_dac_route_o, .effect_3d_o, .dmic_enable_o,
        .dmic_osr_o);
    audio_host_model audio_host_model_inst (.bclk_o, .bclk_oe_o, .wclk_o,
        .wclk_oe_o, .bclk_i, .wclk_i);
    initial
    begin
        forever #25 clock_i = ~clock_i;
    end
    task automatic end_sim;
        if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    always @(negedge clock_i)
    begin
        gen <= gen + 8'h01;
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk(string n, logic [15:0] s, e);
        n_tests++;
        if (s !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic pins(logic s, c);
        sda_h = s;
        scl_i = c;
        repeat (4) @(negedge clock_i);
    endtask : pins
    task automatic xbyte(logic [7:0] d, output logic [7:0] r);
        logic a;
        for (int i = 8; i >= 0; i--)
        begin
            a = i > 0 ? d[i-1] : 1'b1;
            pins(a, 1'b0);
            pins(a, 1'b1);
            if (i > 0) r[i-1] = sda_i;
            else ack = !sda_i;
            pins(a, 1'b1);
            pins(a, 1'b0);
        end
    endtask : xbyte
    task automatic start(logic [7:0] a, o, output logic [7:0] r);
        pins(1'b1, 1'b0);
        pins(1'b1, 1'b1);
        pins(1'b0, 1'b1);
        pins(1'b0, 1'b0);
        xbyte(a, r);
        chk("address ack", ack, a[7:1] == ADR);
        xbyte(o, r);
    endtask : start
    task automatic stop;
        pins(1'b0, 1'b0);
        pins(1'b0, 1'b1);
        pins(1'b1, 1'b1);
    endtask : stop
    task automatic wr(logic [6:0] a, logic [7:0] o, d);
        logic [7:0] r;
        start({a, 1'b0}, o, r);
        xbyte(d, r);
        stop();
    endtask : wr
    task automatic rd(logic [7:0] o, e);
        logic [7:0] r;
        start({ADR, 1'b0}, o, r);
        start({ADR, 1'b1}, 8'hff, r);
        stop();
        chk("read data", r, e);
    endtask : rd
    initial
    begin
        repeat (2) @(negedge clock_i);
        resetn_i = 1'b1;
        repeat (3) @(negedge clock_i);
        chk("reset q", pll_q_divider_o, 16'd2);
        chk("reset j", pll_j_multiplier_o, 16'd1);
        rd(8'h03, 8'h10);
        for (int i = 0; i < 4; i++)
        begin
            wr(ADR, 8'h03, {i[0], qv[i], i[2:0]});
            chk("q", pll_q_divider_o, qv[i] < 2 ? qv[i] + 16 : qv[i]);
            chk("p", pll_p_divider_o, i == 0 ? 8 : i);
            chk("enable", pll_enable_o, i[0]);
        end
        wr(ADR, 8'h04, 8'hff);
        chk("j", pll_j_multiplier_o, 16'd63);
        rd(8'h04, 8'hfc);
        wr(ADR, 8'h05, 8'h9c);
        wr(ADR, 8'h06, 8'h3f);
        chk("fraction", pll_fraction_o, 16'd9999);
        rd(8'h06, 8'h3c);
        for (int r = 0; r < 4; r++)
        begin
            v = {r[0], r[1], r[1], r[1:0], r[1:0], 1'b1};
            wr(ADR, 8'h07, v);
            chk("datapath", {fs_ref_44k1_o, adc_dual_rate_o, dac_dual_rate_o,
                left_dac_route_o, right_dac_route_o}, v[7:1]);
            rd(8'h07, {v[7:1], 1'b0});
        end
        codec_powered_down_i = 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            v = {m[0], m[0], 1'b1, m[1], 1'b0, m[1], m[1:0]};
            wr(ADR, 8'h08, v);
            chk("clock oe", {bclk_oe_o, wclk_oe_o}, {2{m == 3}});
            chk("effect", effect_3d_o, m[1]);
            chk("mic", dmic_osr_o, m == 0 ? 0 : 256 >> m);
            rd(8'h08, v);
        end
        wr(ADR, 8'h08, 8'hc0);
        chk("clock oe", {bclk_oe_o, wclk_oe_o}, 16'h0000);
        codec_powered_down_i = 1'b0;
        repeat (3) @(negedge clock_i);
        chk("clock oe", {bclk_oe_o, wclk_oe_o}, 16'h0003);
        wr(ADR + 7'h01, 8'h07, 8'h00);
        rd(8'h09, 8'h00);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
